/* File: logic/adcc_pkg.sv */
// Constants, carrier types and states for the two-pass converter controller.
// Assumes one 10 MHz clock; all pins arrive from outside and are synchronised.
// Functional notes
// - A sample strobe while idle starts a new conversion
// - Strobe holds; controller ends hold via release
// - Two 8-bit passes build one 13-bit word
// - Path select: pass1 hi=1, reference 01, residue 00
// - Pass-one byte plus dither drives the DAC
// - Scaled residue added to pass-one word
// - Reset reference routed between the two passes
// - Serial output only after active-low request
// - Channel-two controller drives both boards' controls; a slave copies only the peer path selects
// - Attenuator two: 0-12 dB, or ground
// - Attenuator three: 0-14 dB, 2 dB steps
// - Attenuator settings arrive through serial chain
// - Offset setting shifted in, latched during autozero
// - Overrange is OR of three; half-range separate
package adcc_pkg;
  localparam int AD_W = 8; // Converter width
  localparam int WORD_W = 13; // Sample word width
  localparam int DITH_W = 5; // Dither width below the pass-one byte
  localparam int RES_SHIFT = 1; // Residue scale-down
  localparam int CFG_W = 14; // Config chain length
  localparam int CLK_NS = 100; // Clock period
  localparam int REF_NS = 1000; // Least time on the reset reference
  localparam int REF_CYC = (REF_NS + CLK_NS - 1) / CLK_NS; // Rounded up
  localparam int ADDR_W = 5;
  localparam logic [4:0] A_STATUS = 5'h00; // Read-only sticky events
  localparam logic [4:0] A_CLEAR = 5'h04; // Write-one-to-clear
  localparam logic [4:0] A_ENABLE = 5'h08; // Interrupt enables
  localparam logic [4:0] A_CTRL = 5'h0c; // Bit 0 dither enable
  localparam logic [4:0] A_RESULT = 5'h10; // Last sample
  localparam logic [4:0] A_CONFIG = 5'h14; // Latched settings
  localparam int EV_W = 4;
  localparam int EV_DONE = 0; // Sample complete
  localparam int EV_OVR = 1; // Overrange rose
  localparam int EV_MISS = 2; // Strobe while busy
  localparam int EV_SENT = 3; // Serial word shifted out
  localparam logic [0:0] CTRL_RST = 1'h1;
  localparam logic [2:0] ATT2_GND = 3'h7; // Grounds following amplifier
  localparam logic [4:0] LFSR_SEED = 5'h01;
  typedef enum logic [2:0] {S_IDLE, S_P1, S_P1W, S_REF, S_P2, S_P2W} adcc_state_t;
  typedef struct packed {logic hi; logic lo;} adcc_path_t;
  typedef struct packed {logic [7:0] offset; logic [2:0] att3; logic [2:0] att2;} adcc_cfg_t;
  typedef struct packed {
    logic [7:0] ad_data; logic is_master; logic half_neg; logic half_pos; logic in_ovl;
    logic ovr_neg; logic ovr_pos; logic autozero; logic cfg_load; logic cfg_data; logic cfg_clk;
    logic peer_lo; logic peer_hi; logic dreq_n; logic ad_done; logic strobe;
  } adcc_pins_t;
endpackage : adcc_pkg

/* File: logic/adcc_ctrl.sv */
// Two-pass subranging converter controller: sequencing, dither, serial out,
// config decode, overload flags and a small register port with interrupt.
// Assumes all pin inputs are asynchronous; the register port is on sys_clk.
`timescale 1ns/1ns
module adcc_ctrl (
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic clk_en,
  input wire logic sample_strobe,
  input wire logic ad_done,
  input wire logic [7:0] ad_data,
  input wire logic data_request_n,
  input wire logic is_master,
  input wire logic peer_sel_hi,
  input wire logic peer_sel_lo,
  input wire logic cfg_clk,
  input wire logic cfg_data,
  input wire logic cfg_load,
  input wire logic autozero,
  input wire logic ovr_pos,
  input wire logic ovr_neg,
  input wire logic input_overload_in,
  input wire logic half_pos,
  input wire logic half_neg,
  output logic hold_release_ctl,
  output logic path_select_hi,
  output logic path_select_lo,
  output logic sample_strobe_start,
  output logic eoc_out,
  output logic [adcc_pkg::WORD_W-1:0] dac_word,
  output logic ser_data,
  output logic ser_active,
  output adcc_pkg::adcc_cfg_t cfg_out,
  output logic att2_ground,
  output logic overrange_flag,
  output logic half_range_flag,
  input wire logic [adcc_pkg::ADDR_W-1:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [31:0] reg_rdata,
  output logic irq
);
  import adcc_pkg::*;

  adcc_pins_t pin_raw, s1_q, s2_q, s3_q; // Two-stage sync plus edge history
  localparam adcc_pins_t PINS_IDLE = '{dreq_n: 1'b1, is_master: 1'b1, default: '0}; // No false edge after reset
  logic strobe_rise, done_rise, dreq_fall, cclk_rise, cload_rise;

  assign pin_raw = '{ad_data, is_master, half_neg, half_pos, input_overload_in, ovr_neg, ovr_pos,
                     autozero, cfg_load, cfg_data, cfg_clk, peer_sel_lo, peer_sel_hi, data_request_n,
                     ad_done, sample_strobe};

  // Synchroniser; s1 feeds only s2, edges compare s2 with s3
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      s1_q <= PINS_IDLE;
      s2_q <= PINS_IDLE;
      s3_q <= PINS_IDLE;
    end else if (clk_en) begin
      s1_q <= pin_raw;
      s2_q <= s1_q;
      s3_q <= s2_q;
    end
  end

  always_comb begin
    strobe_rise = s2_q.strobe & ~s3_q.strobe;
    done_rise = s2_q.ad_done & ~s3_q.ad_done;
    dreq_fall = ~s2_q.dreq_n & s3_q.dreq_n;
    cclk_rise = s2_q.cfg_clk & ~s3_q.cfg_clk;
    cload_rise = s2_q.cfg_load & ~s3_q.cfg_load;
  end

  // Conversion sequencer state
  adcc_state_t st_q, st_d;
  adcc_path_t path_q, path_d;
  logic hold_q, hold_d, valid_q, valid_d, eoc_q, eoc_d;
  logic [3:0] ref_cnt_q, ref_cnt_d;
  logic [WORD_W-1:0] first_q, first_d, result_q, result_d;
  logic [DITH_W-1:0] lfsr_q, lfsr_d;
  logic signed [WORD_W-1:0] residue; // Pass-two byte, centred and scaled
  logic ser_load, ser_done, dither_en, ev_done, ev_miss;
  logic [EV_W-1:0] ev;

  // Offset-binary byte to signed, then shift down toward pass-one LSB
  always_comb begin
    residue = $signed({{(WORD_W-AD_W){~s2_q.ad_data[7]}}, ~s2_q.ad_data[7], s2_q.ad_data[6:0]}) >>> RES_SHIFT;
  end

  // Sequencer next state
  always_comb begin
    st_d = st_q;
    path_d = path_q;
    hold_d = hold_q;
    valid_d = valid_q & ~ser_load; // Word consumed by the serial shifter
    eoc_d = 1'b0;
    ref_cnt_d = ref_cnt_q;
    first_d = first_q;
    result_d = result_q;
    lfsr_d = lfsr_q;
    ev_done = 1'b0;
    ev_miss = strobe_rise && (st_q != S_IDLE); // Sample lost while converting
    unique case (st_q)
      S_IDLE: begin
        path_d = '{hi: 1'b1, lo: 1'b0}; // Park on the first-pass input
        if (strobe_rise) begin
          hold_d = 1'b0;
          st_d = S_P1;
        end
      end
      S_P1: st_d = S_P1W; // One-cycle start of pass one
      S_P1W: begin
        if (done_rise) begin
          first_d = {s2_q.ad_data, dither_en ? lfsr_q : {DITH_W{1'b0}}};
          path_d = '{hi: 1'b0, lo: 1'b1};
          ref_cnt_d = 4'(REF_CYC - 1);
          st_d = S_REF;
        end
      end
      S_REF: begin
        if (ref_cnt_q == 4'h0) begin
          path_d = '{hi: 1'b0, lo: 1'b0};
          st_d = S_P2;
        end else begin
          ref_cnt_d = ref_cnt_q - 4'h1;
        end
      end
      S_P2: st_d = S_P2W; // One-cycle start of pass two
      S_P2W: begin
        if (done_rise) begin
          result_d = first_q + $unsigned(residue);
          hold_d = 1'b1;
          valid_d = 1'b1;
          eoc_d = 1'b1; // Tells the other board this conversion ended
          ev_done = 1'b1;
          lfsr_d = {lfsr_q[3:0], lfsr_q[4] ^ lfsr_q[2]}; // New dither per sample
          path_d = '{hi: 1'b1, lo: 1'b0};
          st_d = S_IDLE;
        end
      end
    endcase
    if (!s2_q.is_master) begin
      path_d = '{hi: s2_q.peer_hi, lo: s2_q.peer_lo};
    end
  end

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      st_q <= S_IDLE;
      path_q <= '{hi: 1'b1, lo: 1'b0};
      hold_q <= 1'b1;
      valid_q <= 1'b0;
      eoc_q <= 1'b0;
      ref_cnt_q <= 4'h0;
      first_q <= '0;
      result_q <= '0;
      lfsr_q <= LFSR_SEED;
    end else if (clk_en) begin
      st_q <= st_d;
      path_q <= path_d;
      hold_q <= hold_d;
      valid_q <= valid_d;
      eoc_q <= eoc_d;
      ref_cnt_q <= ref_cnt_d;
      first_q <= first_d;
      result_q <= result_d;
      lfsr_q <= lfsr_d;
    end
  end

  assign hold_release_ctl = hold_q;
  assign path_select_hi = path_q.hi;
  assign path_select_lo = path_q.lo;
  assign sample_strobe_start = (st_q == S_P1) || (st_q == S_P2);
  assign eoc_out = eoc_q;
  assign dac_word = first_q;

  // Serial shifter: MSB first, one bit per cycle, only on request
  logic [WORD_W-1:0] sh_q, sh_d;
  logic [3:0] bit_q, bit_d;
  logic sact_q, sact_d, sdat_q, sdat_d;

  always_comb begin
    ser_load = dreq_fall && valid_q && !sact_q;
    ser_done = sact_q && (bit_q == 4'h1);
    sh_d = sh_q;
    bit_d = bit_q;
    sact_d = sact_q;
    sdat_d = sdat_q;
    if (ser_load) begin
      sh_d = result_q;
      bit_d = 4'(WORD_W);
      sact_d = 1'b1;
      sdat_d = result_q[WORD_W-1];
    end else if (sact_q) begin
      sh_d = {sh_q[WORD_W-2:0], 1'b0};
      bit_d = bit_q - 4'h1;
      sact_d = !ser_done;
      sdat_d = ser_done ? 1'b0 : sh_q[WORD_W-2];
    end
  end

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      sh_q <= '0;
      bit_q <= 4'h0;
      sact_q <= 1'b0;
      sdat_q <= 1'b0;
    end else if (clk_en) begin
      sh_q <= sh_d;
      bit_q <= bit_d;
      sact_q <= sact_d;
      sdat_q <= sdat_d;
    end
  end

  assign ser_data = sdat_q;
  assign ser_active = sact_q;

  // Config chain and overload flags
  logic [CFG_W-1:0] csh_q, csh_d;
  adcc_cfg_t cfg_q, cfg_d;
  logic ovl_q, ovl_d, half_q, half_d;

  always_comb begin
    csh_d = cclk_rise ? {csh_q[CFG_W-2:0], s2_q.cfg_data} : csh_q;
    cfg_d = cfg_q;
    if (cload_rise) begin
      cfg_d.att2 = csh_q[2:0];
      cfg_d.att3 = csh_q[5:3];
      if (s2_q.autozero) begin
        cfg_d.offset = csh_q[13:6];
      end
    end
    ovl_d = s2_q.ovr_pos | s2_q.ovr_neg | s2_q.in_ovl;
    half_d = s2_q.half_pos | s2_q.half_neg;
  end

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      csh_q <= '0;
      cfg_q <= '0;
      ovl_q <= 1'b0;
      half_q <= 1'b0;
    end else if (clk_en) begin
      csh_q <= csh_d;
      cfg_q <= cfg_d;
      ovl_q <= ovl_d;
      half_q <= half_d;
    end
  end

  // Grounding code shows as zero step so the amplifier never sees both
  always_comb begin
    cfg_out = cfg_q;
    att2_ground = (cfg_q.att2 == ATT2_GND);
    if (att2_ground) begin
      cfg_out.att2 = 3'h0;
    end
  end
  assign overrange_flag = ovl_q;
  assign half_range_flag = half_q;

  // Register port and sticky interrupt status; a set beats a same-cycle clear
  logic [EV_W-1:0] stat_q, stat_d, en_q, en_d;
  logic [0:0] ctrl_q, ctrl_d;
  logic [31:0] rd_q, rd_d;

  always_comb begin
    ev[EV_DONE] = ev_done;
    ev[EV_MISS] = ev_miss;
    ev[EV_OVR] = ovl_d & ~ovl_q;
    ev[EV_SENT] = ser_done;
    stat_d = stat_q;
    en_d = en_q;
    ctrl_d = ctrl_q;
    rd_d = 32'h0;
    if (reg_wr) begin
      unique case (reg_addr)
        A_CLEAR: stat_d = stat_q & ~reg_wdata[EV_W-1:0];
        A_ENABLE: en_d = reg_wdata[EV_W-1:0];
        A_CTRL: ctrl_d = reg_wdata[0:0];
        default: ;
      endcase
    end
    stat_d = stat_d | ev;
    if (reg_rd) begin
      unique case (reg_addr)
        A_STATUS: rd_d = {28'h0, stat_q};
        A_ENABLE: rd_d = {28'h0, en_q};
        A_CTRL: rd_d = {31'h0, ctrl_q};
        A_RESULT: rd_d = {19'h0, result_q};
        A_CONFIG: rd_d = {17'h0, att2_ground, cfg_q};
        default: rd_d = 32'h0; // Unmapped reads as zero
      endcase
    end
  end

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      stat_q <= '0;
      en_q <= '0;
      ctrl_q <= CTRL_RST;
      rd_q <= 32'h0;
    end else if (clk_en) begin
      stat_q <= stat_d;
      en_q <= en_d;
      ctrl_q <= ctrl_d;
      rd_q <= rd_d;
    end
  end

  assign dither_en = ctrl_q[0];
  assign reg_rdata = rd_q;
  assign irq = |(stat_q & en_q);

  // Checks; stalled cycles are excluded
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (rst || !clk_en);
  a_strobe_starts: assert property (st_q == S_IDLE && strobe_rise |=> st_q == S_P1) else $error("no start");
  a_hold_enter: assert property (st_q == S_IDLE && strobe_rise |=> !hold_release_ctl) else $error("no hold");
  a_pass1_path: assert property (s2_q.is_master && st_q == S_P1 |-> path_select_hi) else $error("pass1 path");
  a_ref_path: assert property (s2_q.is_master && $rose(st_q == S_REF) |->
    (!path_select_hi && path_select_lo)[*8]) else $error("reference path");
  a_resid_path: assert property (s2_q.is_master && st_q == S_P2 |-> !path_select_hi && !path_select_lo)
    else $error("residue path");
  a_dac_merge: assert property (st_q == S_P1W && done_rise |=>
    dac_word[WORD_W-1:DITH_W] == $past(s2_q.ad_data)) else $error("dac word");
  a_final_sum: assert property (st_q == S_P2W && done_rise |=> result_q == $past(first_q) +
    13'(($signed({1'b0, $past(s2_q.ad_data)}) - 10'sd128) >>> RES_SHIFT)) else $error("final sum");
  a_ser_request: assert property ($rose(ser_active) |-> $past(dreq_fall)) else $error("unrequested send");
  a_ser_length: assert property (ser_load |=> ser_active[*8]) else $error("short word");
  a_slave_follow: assert property (!s2_q.is_master |=> path_select_hi == $past(s2_q.peer_hi))
    else $error("slave path");
  a_ovl_or: assert property (overrange_flag == $past(s2_q.ovr_pos | s2_q.ovr_neg | s2_q.in_ovl))
    else $error("overrange");
  a_release_late: assert property ($rose(hold_release_ctl) |-> $past(st_q) == S_P2W) else $error("early release");
  c_full_sample_strobe: cover property (st_q == S_P2W && done_rise ##1 st_q == S_IDLE);
  c_serial_out: cover property (ser_load ##[1:20] !ser_active);
  c_slave_run: cover property (!s2_q.is_master && st_q == S_REF);
  c_ground_cfg: cover property (att2_ground);
endmodule : adcc_ctrl

/* File: sim/adcc_filter_model.sv */
// Behavioural digital filter: asks for one sample word and shifts it in.
// Assumes the word arrives MSB first, one bit a cycle while ser_active is high.
`timescale 1ns/1ns
module adcc_filter_model (
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic ask,
  input wire logic ser_data,
  input wire logic ser_active,
  output logic data_request_n,
  output logic [12:0] rx_word,
  output logic [4:0] rx_bits
);
  logic [2:0] low_q; // Request low time left
  // Held low six cycles so the pin synchroniser surely sees the fall
  assign data_request_n = (low_q == 3'h0);
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      low_q <= 3'h0;
      rx_word <= 13'h0;
      rx_bits <= 5'h0;
    end else begin
      if (ask) begin
        low_q <= 3'h6;
        rx_bits <= 5'h0;
      end else if (low_q != 3'h0) begin
        low_q <= low_q - 3'h1;
      end
      // Shift in MSB first, count bits of this word
      if (ser_active) begin
        rx_word <= {rx_word[11:0], ser_data};
        rx_bits <= rx_bits + 5'h1;
      end
    end
  end
endmodule : adcc_filter_model

/* File: sim/tb_two_pass_subranging_adc_ctrl.sv */
// Self-checking bench for the converter controller and its register port.
// Assumes the filter model on the serial side; converter pins are driven here.
`timescale 1ns/1ns
module tb_two_pass_subranging_adc_ctrl;
  import adcc_pkg::*;
  logic sys_clk, rst, clk_en, sample_strobe, ad_done, data_request_n, is_master;
  logic peer_sel_hi, peer_sel_lo, cfg_clk, cfg_data, cfg_load, autozero;
  logic ovr_pos, ovr_neg, input_overload_in, half_pos, half_neg, ask, dith;
  logic [7:0] ad_data;
  logic hold_release_ctl, path_select_hi, path_select_lo, sample_strobe_start, eoc_out;
  logic [WORD_W-1:0] dac_word;
  logic ser_data, ser_active, att2_ground, overrange_flag, half_range_flag, irq;
  adcc_cfg_t cfg_out;
  logic [ADDR_W-1:0] reg_addr;
  logic [31:0] reg_wdata, reg_rdata;
  logic reg_wr, reg_rd;
  logic [12:0] rx_word;
  logic [4:0] rx_bits;
  int err_count = 0;
  int check_count = 0;
  adcc_ctrl DUT (.sys_clk, .rst, .clk_en, .sample_strobe, .ad_done, .ad_data, .data_request_n,
    .is_master, .peer_sel_hi, .peer_sel_lo, .cfg_clk, .cfg_data, .cfg_load, .autozero, .ovr_pos,
    .ovr_neg, .input_overload_in, .half_pos, .half_neg, .hold_release_ctl, .path_select_hi,
    .path_select_lo, .sample_strobe_start, .eoc_out, .dac_word, .ser_data, .ser_active, .cfg_out,
    .att2_ground, .overrange_flag, .half_range_flag, .reg_addr, .reg_wdata, .reg_wr, .reg_rd,
    .reg_rdata, .irq);
  adcc_filter_model filt (.sys_clk, .rst, .ask, .ser_data, .ser_active, .data_request_n,
    .rx_word, .rx_bits);
  // Clock of 100 ns period
  initial begin
    sys_clk = 1'b0;
    forever #50 sys_clk = ~sys_clk;
  end
  task chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp) begin
      err_count++;
      $display("ERROR %s expected %h seen %h", name, exp, seen);
    end
  endtask : chk
  task conclude;
    if (err_count == 0 && check_count > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask : conclude
  task tick(input int n);
    repeat (n) @(posedge sys_clk);
    #1;
  endtask : tick
  task wr(input logic [4:0] a, input logic [31:0] d);
    @(posedge sys_clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge sys_clk);
    reg_wr <= 1'b0;
  endtask : wr
  // Read data stands only in the cycle after the strobe
  task rdchk(input string name, input logic [4:0] a, input logic [31:0] exp);
    @(posedge sys_clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge sys_clk);
    reg_rd <= 1'b0;
    #1 chk(name, reg_rdata, exp);
  endtask : rdchk
  function automatic logic cond(input int s);
    case (s)
      0: return sample_strobe_start;
      1: return path_select_lo & ~path_select_hi;
      default: return eoc_out;
    endcase
  endfunction : cond
  // Bounded wait on a design event
  task wait_on(input int s);
    for (int i = 0; i < 300; i++) begin
      tick(1);
      if (cond(s) === 1'b1) break;
    end
    chk("wait", 32'(cond(s)), 32'h1);
  endtask : wait_on
  // One full two-pass sample; miss adds a strobe while busy
  task convert(input logic [7:0] a1, input logic [7:0] a2, input logic miss);
    int n;
    logic [12:0] dac;
    logic signed [8:0] r;
    @(posedge sys_clk);
    ad_data <= a1;
    sample_strobe <= 1'b1;
    wait_on(0);
    chk("hold", 32'(hold_release_ctl), 32'h0);
    chk("pass1", 32'(path_select_hi), 32'h1);
    @(posedge sys_clk);
    sample_strobe <= 1'b0;
    if (miss) begin
      tick(4);
      sample_strobe <= 1'b1;
      tick(4);
      sample_strobe <= 1'b0;
    end
    @(posedge sys_clk);
    ad_done <= 1'b1;
    wait_on(1);
    dac = dac_word;
    chk("dac_hi", 32'(dac[12:5]), 32'(a1));
    if (!dith) chk("dac_lo", 32'(dac[4:0]), 32'h0);
    else chk("dith", 32'(dac[4:0] != 5'h0), 32'h1);
    n = 1;
    do begin
      @(posedge sys_clk);
      ad_done <= 1'b0;
      ad_data <= a2;
      #1 n++;
    end while (cond(1) === 1'b1 && n < 50);
    chk("ref_len", n - 1, REF_CYC);
    chk("pass2", 32'({path_select_hi, path_select_lo}), 32'h0);
    chk("pass2_start", 32'(sample_strobe_start), 32'h1);
    tick(3);
    ad_done <= 1'b1;
    wait_on(2);
    chk("release", 32'(hold_release_ctl), 32'h1);
    chk("idle_path", 32'({path_select_hi, path_select_lo}), 32'h2);
    r = $signed({1'b0, a2}) - 9'sd128;
    dac = dac + 13'(r >>> 1);
    @(posedge sys_clk);
    ad_done <= 1'b0;
    rdchk("result", A_RESULT, 32'(dac));
  endtask : convert
  // Config word shifted MSB first, then latched
  task cfg_send(input logic [13:0] w);
    for (int i = 13; i >= 0; i--) begin
      cfg_data <= w[i];
      tick(4);
      cfg_clk <= 1'b1;
      tick(4);
      cfg_clk <= 1'b0;
    end
    cfg_load <= 1'b1;
    tick(4);
    cfg_load <= 1'b0;
    tick(5);
  endtask : cfg_send
  initial begin
    {clk_en, is_master} = 2'h3;
    {sample_strobe, ad_done, peer_sel_hi, peer_sel_lo, cfg_clk, cfg_data, cfg_load, autozero} = 8'h0;
    {ovr_pos, ovr_neg, input_overload_in, half_pos, half_neg, ask, reg_wr, reg_rd} = 8'h0;
    {ad_data, reg_addr, reg_wdata, dith} = '0;
    rst = 1'b1;
    repeat (12) @(posedge sys_clk);
    rst <= 1'b0;
    tick(2);
    chk("rst_path", 32'({hold_release_ctl, path_select_hi, path_select_lo}), 32'h6);
    rdchk("ctrl", A_CTRL, 32'h1);
    rdchk("unmapped", 5'h1c, 32'h0);
    wr(A_CTRL, 32'h0);
    wr(A_ENABLE, 32'h1);
    convert(8'ha5, 8'h90, 1'b0);
    chk("irq_on", 32'(irq), 32'h1);
    chk("no_ser", 32'({ser_active, rx_bits}), 32'h0);
    ask <= 1'b1;
    tick(1);
    ask <= 1'b0;
    tick(40);
    chk("ser_bits", 32'(rx_bits), 32'd13);
    chk("ser_word", 32'(rx_word), 32'h14a8);
    rdchk("status", A_STATUS, 32'h9);
    ask <= 1'b1;
    tick(1);
    ask <= 1'b0;
    tick(40);
    chk("no_resend", 32'(rx_bits), 32'h0);
    wr(A_CLEAR, 32'hf);
    wr(A_ENABLE, 32'h0);
    convert(8'h00, 8'h10, 1'b1);
    rdchk("miss", A_STATUS, 32'h5);
    chk("irq_mask", 32'(irq), 32'h0);
    wr(A_ENABLE, 32'h4);
    tick(1);
    chk("irq_miss", 32'(irq), 32'h1);
    wr(A_CLEAR, 32'hf);
    tick(1);
    chk("irq_clr", 32'(irq), 32'h0);
    wr(A_CTRL, 32'h1);
    dith = 1'b1;
    convert(8'h7f, 8'hff, 1'b0);
    // Each overload source alone must raise the combined flag
    for (int k = 0; k < 3; k++) begin
      {ovr_pos, ovr_neg, input_overload_in} <= 3'(1 << k);
      tick(5);
      chk("ovr", 32'(overrange_flag), 32'h1);
      {ovr_pos, ovr_neg, input_overload_in} <= 3'h0;
      tick(5);
      chk("ovr_off", 32'(overrange_flag), 32'h0);
    end
    half_neg <= 1'b1;
    tick(5);
    chk("half", 32'({overrange_flag, half_range_flag}), 32'h1);
    half_neg <= 1'b0;
    autozero <= 1'b1;
    cfg_send({8'h3c, 3'h7, 3'h7});
    chk("cfg_gnd", 32'({cfg_out, att2_ground}), 32'h1e71);
    autozero <= 1'b0;
    cfg_send({8'hc3, 3'h2, 3'h6});
    chk("cfg_att", 32'({cfg_out, att2_ground}), 32'h1e2c);
    // Lowest range: host sends all attenuators at zero, offset kept
    cfg_send(14'h0);
    chk("cfg_zero", 32'({cfg_out, att2_ground}), 32'h1e00);
    is_master <= 1'b0;
    peer_sel_lo <= 1'b1;
    tick(5);
    chk("slave", 32'({path_select_hi, path_select_lo}), 32'h1);
    is_master <= 1'b1;
    tick(5);
    chk("master", 32'({path_select_hi, path_select_lo}), 32'h2);
    // A low enable freezes every controller flop, the pin synchroniser too
    clk_en <= 1'b0;
    ovr_pos <= 1'b1;
    tick(5);
    chk("frozen", 32'(overrange_flag), 32'h0);
    clk_en <= 1'b1;
    tick(5);
    chk("thawed", 32'(overrange_flag), 32'h1);
    ovr_pos <= 1'b0;
    conclude();
  end
  // Hang guard, well beyond the several hundred cycles of the run
  initial begin
    repeat (20000) @(posedge sys_clk);
    err_count++;
    conclude();
  end
endmodule : tb_two_pass_subranging_adc_ctrl
